/* hdl/apm_pkg.sv */
// shared constants for the converter power-mode and coding control
package apm_pkg;
    localparam int CLK_HZ             = 50000000;
    localparam int CONV_CLK_HZ        = 1560000;
    localparam int CONV_DIV           = CLK_HZ / CONV_CLK_HZ;  // rounds down, 32
    localparam int CONV_STEPS         = 12;
    localparam int RES_W              = 12;

    // control byte field positions
    localparam int CB_START_BIT       = 7;
    localparam int CB_SEL_HI          = 6;
    localparam int CB_SEL_LO          = 4;
    localparam int CB_RNG_BIT         = 3;
    localparam int CB_POL_BIT         = 2;
    localparam int CB_PM_HI_BIT       = 1;
    localparam int CB_PM_LO_BIT       = 0;

    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [11:0] RES_RST   = 12'h000;
    localparam logic [11:0] BIP_FLIP  = 12'h800;

    // register map, word offsets in bytes
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_RESULT = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_EVENT  = 4'hc;

    // event register bits
    localparam int EV_CTRL_BIT        = 0;
    localparam int EV_WAKE_BIT        = 1;
    localparam int EV_STOP_BIT        = 2;

    localparam logic [31:0] UNMAPPED  = 32'hdead_beef;

    typedef enum logic [1:0] {PM_NORMAL, PM_STANDBY, PM_DEEP} apm_pmode_t;
endpackage

/* hdl/apm_code.sv */
`timescale 1ns/1ps
// result coding: straight binary or two's complement
module apm_code
    import apm_pkg::*;
#(
    parameter int W = RES_W
) (
    input  wire logic [W-1:0] raw_i,
    input  wire logic         bipolar_i,
    output logic [W-1:0]      coded_o
);
    // raw is offset binary over the span; flipping msb gives two's complement
    assign coded_o = bipolar_i ? (raw_i ^ BIP_FLIP[W-1:0]) : raw_i;
endmodule

/* hdl/apm_conv.sv */
`timescale 1ns/1ps
// conversion sequencer paced by the internal conversion clock enable
module apm_conv
    import apm_pkg::*;
#(
    parameter int DIV   = CONV_DIV,
    parameter int STEPS = CONV_STEPS
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      busy_o,
    output logic      done_o
);
    logic [7:0] div_reg;
    logic [4:0] step_reg;
    logic       busy_reg;
    logic       done_reg;
    wire        tick = (div_reg == 8'(DIV - 1));

    always_ff @(posedge core_clk_i) begin
        if (rst_i || abort_i || !busy_reg || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        done_reg <= 1'b0;
        if (rst_i || abort_i) begin
            busy_reg <= 1'b0;
            step_reg <= 5'h00;
        end else if (!busy_reg && start_i) begin
            busy_reg <= 1'b1;
            step_reg <= 5'h00;
        end else if (busy_reg && tick) begin
            if (step_reg == 5'(STEPS - 1)) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end
            step_reg <= step_reg + 5'h01;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule

/* hdl/apm_ctrl.sv */
`timescale 1ns/1ps
// power-mode and output-coding control top with avalon-mm register access
// Behaviour
// - after reset, normal operation, waiting for an addressed bus start
// - reset clears control byte and result register to zero
// - enter standby or deep sleep per the two power-mode bits
// - software sleep waits until the running conversion finishes
// - interface stays alive and result readable in every sleep state
// - only start plus matching address with write direction wakes
// - wake takes effect on the bit after the matching write address
// - hw_off_n low forces deep sleep at once and aborts conversion
// - standby keeps bandgap and reference buffer enabled
// - deep sleep keeps only bandgap, buffer and converter off
// - unipolar result is straight binary, step full scale over 4096
// - bipolar result is two's complement, step twice full scale over 4096
// - upper bit 0 normal, 1,0 standby, 1,1 deep sleep
// - bit 2 of control byte picks unipolar or bipolar coding
module apm_ctrl
    import apm_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire logic                hw_off_n_i,
    input  wire logic                bus_start_i,
    input  wire logic                addr_match_wr_i,
    input  wire logic                bit_clk_i,
    input  wire logic                bus_stop_i,
    input  wire logic [RES_W-1:0]    raw_result_i,
    output logic                     bandgap_en_o,
    output logic                     refbuf_en_o,
    output logic                     conv_en_o,
    output logic                     sampling_o,
    output logic [2:0]               channel_o,
    output logic                     range_o,
    output logic [RES_W-1:0]         result_o
);
    import apm_pkg::*;

    // register state
    logic [7:0]        ctrl_reg;
    logic [RES_W-1:0]  result_reg;
    apm_pmode_t        mode_reg;
    apm_pmode_t        mode_next;
    logic              pend_reg;
    logic              armed_reg;
    logic              listen_reg;
    logic              acq_reg;
    logic [2:0]        event_reg;
    logic [31:0]       rdata_reg;
    logic              ack_reg;
    logic              wait_reg;
    logic              bg_reg;
    logic              rb_reg;
    logic              cv_reg;

    function automatic apm_pmode_t decode_pm(input logic [7:0] cb);
        if (!cb[CB_PM_HI_BIT]) begin
            return PM_NORMAL;
        end
        return cb[CB_PM_LO_BIT] ? PM_DEEP : PM_STANDBY;
    endfunction

    // bus decode
    wire        req       = (avs_read_i || avs_write_i) && !ack_reg;
    // writes land on the edge where the master sees waitrequest low, never earlier
    wire        wr_ctrl   = avs_write_i && ack_reg && (avs_address_i == OFS_CTRL);
    wire        wr_event  = avs_write_i && ack_reg && (avs_address_i == OFS_EVENT);
    wire        asleep    = (mode_reg != PM_NORMAL);
    wire        hw_off    = !hw_off_n_i;

    // wake: start then matching write address, armed; takes effect on next bit
    wire        wake_arm  = listen_reg && addr_match_wr_i && asleep && !hw_off;
    wire        wake_fire = armed_reg && bit_clk_i;

    wire        conv_busy;
    wire        conv_done;
    wire        conv_start = acq_reg && bus_stop_i && !asleep && !hw_off;
    wire [RES_W-1:0] coded;
    // acquisition runs straight into conversion, so it holds off sleep as well
    wire        sleep_ok   = pend_reg && !conv_busy && !conv_start && !acq_reg;

    apm_conv u_conv (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (conv_start),
        .abort_i    (hw_off),
        .busy_o     (conv_busy),
        .done_o     (conv_done)
    );

    apm_code u_code (
        .raw_i     (raw_result_i),
        .bipolar_i (ctrl_reg[CB_POL_BIT]),
        .coded_o   (coded)
    );

    // power-mode next state
    always_comb begin
        mode_next = mode_reg;
        if (hw_off) begin
            mode_next = PM_DEEP;
        end else if (wake_fire) begin
            mode_next = PM_NORMAL;
        end else if (sleep_ok) begin
            mode_next = decode_pm(ctrl_reg);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_reg <= PM_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // pending software sleep, applied once conversion is over
    always_ff @(posedge core_clk_i) begin
        if (rst_i || hw_off) begin
            pend_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pend_reg <= avs_writedata_i[CB_PM_HI_BIT];
        end else if (sleep_ok) begin
            pend_reg <= 1'b0;
        end
    end

    // start/address tracking; interface logic runs in every mode
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            listen_reg <= 1'b0;
            armed_reg  <= 1'b0;
        end else begin
            if (bus_start_i) begin
                listen_reg <= 1'b1;
            end else if (addr_match_wr_i || bus_stop_i) begin
                listen_reg <= 1'b0;
            end
            if (wake_arm) begin
                armed_reg <= 1'b1;
            end else if (wake_fire || hw_off || bus_stop_i) begin
                armed_reg <= 1'b0;
            end
        end
    end

    // control byte, acquisition and result
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= CTRL_RST;
            result_reg <= RES_RST;
            acq_reg    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= avs_writedata_i[7:0];
            end
            if (wr_ctrl && !asleep && !hw_off) begin
                acq_reg <= 1'b1;
            end else if (bus_stop_i || hw_off) begin
                acq_reg <= 1'b0;
            end
            if (conv_done) begin
                result_reg <= coded;
            end
        end
    end

    // analog enables from mode; software sleep only after conversion done
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bg_reg <= 1'b1;
            rb_reg <= 1'b1;
            cv_reg <= 1'b1;
        end else begin
            bg_reg <= 1'b1;
            rb_reg <= (mode_next != PM_DEEP);
            cv_reg <= (mode_next == PM_NORMAL);
        end
    end

    // sticky events, write one to clear, set wins
    wire [2:0] ev_set = {bus_stop_i, wake_fire, wr_ctrl};
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            event_reg <= 3'h0;
        end else begin
            event_reg <= (event_reg & ~(wr_event ? avs_writedata_i[2:0] : 3'h0)) | ev_set;
        end
    end

    // avalon slave: one wait cycle, answer on second edge
    wire [31:0] rd_mux =
        (avs_address_i == OFS_CTRL)   ? {24'h000000, ctrl_reg} :
        (avs_address_i == OFS_RESULT) ? {20'h00000, result_reg} :
        (avs_address_i == OFS_STATUS) ? {26'h0, pend_reg, conv_busy, hw_off,
                                         acq_reg, mode_reg} :
        (avs_address_i == OFS_EVENT)  ? {29'h0, event_reg} : UNMAPPED;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg  <= req;
            // own flop so the bus sees a registered waitrequest
            wait_reg <= !req;
            if (req && avs_read_i) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o    = rdata_reg;
    assign bandgap_en_o      = bg_reg;
    assign refbuf_en_o       = rb_reg;
    assign conv_en_o         = cv_reg;
    assign sampling_o        = acq_reg;
    assign channel_o         = ctrl_reg[CB_SEL_HI:CB_SEL_LO];
    assign range_o           = ctrl_reg[CB_RNG_BIT];
    assign result_o          = result_reg;

    // checks
    sequence s_wake_armed;
        armed_reg && bit_clk_i && hw_off_n_i;
    endsequence

    hw_off_deep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !hw_off_n_i |=> mode_reg == PM_DEEP && !conv_busy)
        else $error("hw off did not force deep sleep");
    wake_next_bit_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_wake_armed |=> mode_reg == PM_NORMAL)
        else $error("no wake on bit after address");
    no_sleep_busy_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (conv_busy && hw_off_n_i && $past(mode_reg) == PM_NORMAL) |-> mode_reg == PM_NORMAL)
        else $error("sleep during conversion");
    standby_buf_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_reg == PM_STANDBY |-> bandgap_en_o && refbuf_en_o)
        else $error("standby lost reference");
    deep_buf_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_reg == PM_DEEP |-> bandgap_en_o && !refbuf_en_o && !conv_en_o)
        else $error("deep sleep enables wrong");
    mode_decode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (sleep_ok && hw_off_n_i && !wake_fire)
        |=> mode_reg == decode_pm($past(ctrl_reg)))
        else $error("power bits misdecoded");
    result_code_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        conv_done |=> result_reg == ($past(ctrl_reg[CB_POL_BIT])
                                     ? ($past(raw_result_i) ^ BIP_FLIP)
                                     : $past(raw_result_i)))
        else $error("result coding wrong");
    read_sleep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (avs_read_i && !ack_reg && avs_address_i == OFS_RESULT)
        |=> avs_readdata_o == {20'h00000, $past(result_reg)} && !avs_waitrequest_o)
        else $error("result not readable");
    no_false_wake_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (asleep && !armed_reg) |=> mode_reg != PM_NORMAL)
        else $error("woke without addressed write");

    // wake has two steps: an addressed write in sleep arms, the next bit fires
    sequence s_addr_in_sleep;
        listen_reg && addr_match_wr_i && asleep && hw_off_n_i;
    endsequence

    // no disable here: these look at the cycle right after a reset edge
    reset_clear_a: assert property (@(posedge core_clk_i)
        rst_i |=> ctrl_reg == CTRL_RST && result_reg == RES_RST)
        else $error("reset left registers set");
    reset_normal_a: assert property (@(posedge core_clk_i)
        rst_i |=> mode_reg == PM_NORMAL && !listen_reg && !armed_reg)
        else $error("reset did not leave normal mode");
    wake_arm_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_addr_in_sleep |=> armed_reg)
        else $error("addressed write did not arm wake");
    wake_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_wake_armed |=> event_reg[EV_WAKE_BIT])
        else $error("wake not recorded");
    sleep_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pend_reg && (conv_busy || acq_reg) && hw_off_n_i) |=> mode_reg == $past(mode_reg))
        else $error("sleep taken before conversion end");
    abort_now_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !hw_off_n_i |=> !conv_busy && !sampling_o && !conv_en_o)
        else $error("hw off left converter running");
    code_unipolar_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (conv_done && !ctrl_reg[CB_POL_BIT]) |=> result_reg == $past(raw_result_i))
        else $error("unipolar result not straight binary");
    iface_alive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (asleep && avs_read_i && !ack_reg) |=> !avs_waitrequest_o)
        else $error("bus not answered in sleep");
    normal_on_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_reg == PM_NORMAL |-> bandgap_en_o && refbuf_en_o && conv_en_o)
        else $error("normal mode enables wrong");
endmodule

/* verif/apm_link_model.sv */
`timescale 1ns/1ps
// serial bus master stand-in: one-cycle front-end event pulses
module apm_link_model (
    input  wire logic core_clk_i,
    output logic      bus_start_o,
    output logic      addr_match_wr_o,
    output logic      bit_clk_o,
    output logic      bus_stop_o
);
    initial {bus_start_o, addr_match_wr_o, bit_clk_o, bus_stop_o} = 4'h0;
    // k: 0 start, 1 own address with write bit, 2 bit boundary, 3 stop
    task automatic pulse(input int k);
        @(posedge core_clk_i);
        case (k)
            0: bus_start_o <= 1'b1;
            1: addr_match_wr_o <= 1'b1;
            2: bit_clk_o <= 1'b1;
            default: bus_stop_o <= 1'b1;
        endcase
        @(posedge core_clk_i);
        {bus_start_o, addr_match_wr_o, bit_clk_o, bus_stop_o} <= 4'h0;
    endtask
endmodule

/* verif/apm_ctrl_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the power-mode and coding control
module apm_ctrl_tb;
    import apm_pkg::*;
    logic        clk, rst, rd, wr, wait_q, hw_off_n, start, match, bitc, stop;
    logic        bg, rb, cen, samp, rng;
    logic [2:0]  ch;
    logic [3:0]  addr;
    logic [11:0] raw, res;
    logic [31:0] wdata, rdata, q;
    int          err_total, comparisons;

    apm_ctrl u_apm_ctrl (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_q), .hw_off_n_i(hw_off_n),
        .bus_start_i(start), .addr_match_wr_i(match), .bit_clk_i(bitc),
        .bus_stop_i(stop), .raw_result_i(raw), .bandgap_en_o(bg), .refbuf_en_o(rb),
        .conv_en_o(cen), .sampling_o(samp), .channel_o(ch), .range_o(rng),
        .result_o(res));
    apm_link_model u_apm_link_model (.core_clk_i(clk), .bus_start_o(start),
        .addr_match_wr_o(match), .bit_clk_o(bitc), .bus_stop_o(stop));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    function automatic logic [31:0] cb(input logic polarity_select, input logic [1:0] pm);
        return {24'h0, 1'b1, 3'h5, 1'b1, polarity_select, pm};
    endfunction

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (q[4] !== 1'b0 && n < 300);
        if (q[4] !== 1'b0) chk(32'h1, 32'h0);
    endtask

    task automatic convert(input logic polarity_select, input logic [1:0] pm, input logic [11:0] r);
        raw <= r;
        bus(1'b1, OFS_CTRL, cb(polarity_select, pm));
        @(negedge clk);
        chk(samp, 1'b1); // acquisition opens on an awake control write
        u_apm_link_model.pulse(3);
    endtask

    task automatic t_reset();
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q[1:0], PM_NORMAL);
        chk({bg, rb, cen}, 3'h7);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, UNMAPPED);
    endtask

    task automatic t_code();
        logic [11:0] r;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 4; i++) begin
                r = 12'h7ff + 12'(i * 12'h3ff);
                convert(b[0], 2'h0, r);
                wait_idle();
                bus(1'b0, OFS_RESULT, 32'h0);
                chk(q, b ? {~r[11], r[10:0]} : r);
                chk(res, b ? {~r[11], r[10:0]} : r);
            end
        end
        chk({ch, rng}, 4'hb);
    endtask

    task automatic t_sleep(input logic [1:0] pm);
        logic [1:0] em;
        em = pm[1] ? (pm[0] ? PM_DEEP : PM_STANDBY) : PM_NORMAL;
        convert(1'b0, pm, 12'h5a3);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({q[4], q[1:0]}, {1'b1, PM_NORMAL});
        chk(cen, 1'b1);
        wait_idle();
        // mode moves one cycle after busy drops, so look again
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q[1:0], em);
        chk({bg, rb, cen}, pm[1] ? (pm[0] ? 3'h4 : 3'h6) : 3'h7);
        bus(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'h5a3);
        if (pm[1]) begin
            u_apm_link_model.pulse(0);
            u_apm_link_model.pulse(2);
            u_apm_link_model.pulse(1);
            repeat (3) @(posedge clk);
            chk(cen, 1'b0);
            u_apm_link_model.pulse(2);
            repeat (3) @(posedge clk);
            chk({bg, rb, cen}, 3'h7);
        end
    endtask

    task automatic t_hwoff();
        convert(1'b0, 2'h0, 12'h111);
        repeat (20) @(posedge clk);
        hw_off_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({bg, rb, cen}, 3'h4);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({q[4], q[1:0]}, {1'b0, PM_DEEP});
        chk(res, 12'h5a3);
        hw_off_n <= 1'b1;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // whole run is about 5k cycles; this cuts a hang at 50k
    initial begin
        #1000000;
        err_total++;
        end_sim();
    end

    initial begin
        {rst, rd, wr, hw_off_n, addr, wdata, raw} = {1'b1, 2'b00, 1'b1, 4'h0, 32'h0, 12'h0};
        err_total = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_code();
        t_sleep(2'h2);
        t_sleep(2'h2);
        t_sleep(2'h3);
        t_sleep(2'h1);
        t_hwoff();
        end_sim();
    end
endmodule
